// file: shared/ppc_defines.vh
// offsets, fields, keys and reset values of the pwm pin control block
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// register byte offsets
`define PPC_ADR_PIN_CTL    8'h00
`define PPC_ADR_UNLOCK     8'h04
`define PPC_ADR_STATUS     8'h08
`define PPC_ADR_HANDLING   8'h0c

// pin control register fields
`define PPC_HIGH_OWNER     15
`define PPC_LOW_OWNER      14
`define PPC_HIGH_INVERT    13
`define PPC_LOW_INVERT     12
`define PPC_MODE_HI        11
`define PPC_MODE_LO        10
`define PPC_HIGH_FORCE_EN  9
`define PPC_LOW_FORCE_EN   8
`define PPC_FORCE_HI       7
`define PPC_FORCE_LO       6
`define PPC_FAULT_HI       5
`define PPC_FAULT_LO       4
`define PPC_LIMIT_HI       3
`define PPC_LIMIT_LO       2
`define PPC_PIN_CTL_RESET  16'hc000
`define PPC_PIN_CTL_WMASK  16'hfffc

// pair output modes
`define PPC_MODE_COMPL     2'h0
`define PPC_MODE_REDUND    2'h1
`define PPC_MODE_PUSHPULL  2'h2
`define PPC_MODE_INDEP     2'h3

// unlock keys, written in this order
`define PPC_KEY_FIRST      16'h5a5a
`define PPC_KEY_SECOND     16'ha5a5

// status register fields
`define PPC_ST_HIGH_PIN    0
`define PPC_ST_LOW_PIN     1
`define PPC_ST_FAULT       2
`define PPC_ST_LIMIT       3
`define PPC_ST_ARMED       4
`define PPC_ST_REFUSED     5
`define PPC_ST_LOCK_CFG    6
`define PPC_ST_PHASE       7

// handling register fields
`define PPC_HD_FAULT_SEL   0
`define PPC_HD_LIMIT_SEL   1

`endif

// file: verilog/ppc_pin_drive.v
// level and enable selection for one pwm pin
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_drive (
    input  wire owner_i,
    input  wire invert_i,
    input  wire gen_i,
    input  wire force_en_i,
    input  wire force_lvl_i,
    input  wire fault_on_i,
    input  wire fault_lvl_i,
    input  wire limit_on_i,
    input  wire limit_lvl_i,
    input  wire gpio_i,
    input  wire gpio_oe_i,
    output reg  lvl_o,
    output reg  oe_o
);

    // forced levels override the generated one, fault first
    always @* begin
        if (!owner_i) begin
            lvl_o = gpio_i;
            oe_o  = gpio_oe_i;
        end else begin
            oe_o = 1'b1;
            if (fault_on_i) begin
                lvl_o = fault_lvl_i;
            end else if (limit_on_i) begin
                lvl_o = limit_lvl_i;
            end else if (force_en_i) begin
                lvl_o = force_lvl_i;
            end else begin
                lvl_o = gen_i ^ invert_i;
            end
        end
    end

endmodule // ppc_pin_drive

`default_nettype wire

// file: verilog/ppc_top.v
// pwm pin pair output control with wishbone register access
//
// What this block does
// - each pin is driven by the pwm logic when its owner bit is 1 and by gpio when 0, both reset to 1.
// - each pin has a polarity bit, 1 inverting the generated level to make the pin active-low.
// - a two-bit mode field picks independent, push-pull, redundant or complementary pairs, frozen while the module runs.
// - a set force enable makes its pin take its force level bit unless fault or limit forcing is on, otherwise the generator drives it.
// - with fault handling on and a fault active, the pins take the fault level bits.
// - with limit handling on and a limit active, the pins take the limit level bits unless fault forcing is on.
// - with the lock configuration set, a pin control write is taken only after the unlock sequence.
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        pwm_high_raw_i,
    input  wire        pwm_low_raw_i,
    input  wire        pwm_period_start_i,
    input  wire        pwm_module_on_i,
    input  wire        write_lock_config_i,
    input  wire        fault_active_i,
    input  wire        limit_active_i,
    input  wire        gpio_high_i,
    input  wire        gpio_high_oe_i,
    input  wire        gpio_low_i,
    input  wire        gpio_low_oe_i,
    output reg         high_side_pin_o,
    output reg         high_side_pin_oe_o,
    output reg         low_side_pin_o,
    output reg         low_side_pin_oe_o
);

    // unlock sequence states
    localparam [1:0] UL_IDLE  = 2'h0;
    localparam [1:0] UL_FIRST = 2'h1;
    localparam [1:0] UL_ARMED = 2'h2;

    reg  [15:0] pin_io_ctl_ff;
    reg  [15:0] nxt_pin_io_ctl;
    reg  [1:0]  handling_ff;
    reg  [1:0]  nxt_handling;
    reg  [1:0]  unlock_ff;
    reg  [1:0]  nxt_unlock;
    reg         refused_ff;
    reg         nxt_refused;
    reg         lock_cfg_ff;
    reg         phase_ff;
    reg  [31:0] nxt_dat;

    wire        bus_req;
    wire        wr_take;
    wire        wr_ctl;
    wire        wr_unlock;
    wire        wr_status;
    wire        wr_handling;
    wire        ctl_allowed;
    wire [15:0] wr_data16;
    wire [1:0]  pair_mode;
    wire        fault_on;
    wire        limit_on;
    reg         gen_high;
    reg         gen_low;
    wire        high_lvl;
    wire        high_oe;
    wire        low_lvl;
    wire        low_oe;

    // merge write data into a 16-bit register under the byte selects
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [1:0]  sel;
        begin
            lane_merge[7:0]  = sel[0] ? new_val[7:0]  : old_val[7:0];
            lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    // bus decode; a write lands on the edge that sees ack high
    assign bus_req     = wb_cyc_i & wb_stb_i;
    assign wr_take     = bus_req & wb_ack_o & wb_we_i;
    assign wr_ctl      = wr_take & (wb_adr_i == `PPC_ADR_PIN_CTL);
    assign wr_unlock   = wr_take & (wb_adr_i == `PPC_ADR_UNLOCK);
    assign wr_status   = wr_take & (wb_adr_i == `PPC_ADR_STATUS);
    assign wr_handling = wr_take & (wb_adr_i == `PPC_ADR_HANDLING);
    assign wr_data16   = wb_dat_i[15:0];

    // a locked part takes control writes only once armed
    assign ctl_allowed = ~lock_cfg_ff | (unlock_ff == UL_ARMED);

    // next pin control value
    always @* begin
        nxt_pin_io_ctl = pin_io_ctl_ff;
        if (wr_ctl && ctl_allowed) begin
            nxt_pin_io_ctl = lane_merge(pin_io_ctl_ff, wr_data16, wb_sel_i[1:0])
                             & `PPC_PIN_CTL_WMASK;
            // mode field holds while the module is running
            if (pwm_module_on_i) begin
                nxt_pin_io_ctl[`PPC_MODE_HI:`PPC_MODE_LO] =
                    pin_io_ctl_ff[`PPC_MODE_HI:`PPC_MODE_LO];
            end
        end
    end

    // unlock sequence: first key, second key, then one control write
    always @* begin
        nxt_unlock = unlock_ff;
        if (wr_ctl) begin
            nxt_unlock = UL_IDLE;
        end else if (wr_unlock) begin
            case (unlock_ff)
                UL_IDLE: begin
                    if (wr_data16 == `PPC_KEY_FIRST)
                        nxt_unlock = UL_FIRST;
                    else
                        nxt_unlock = UL_IDLE;
                end
                UL_FIRST: begin
                    if (wr_data16 == `PPC_KEY_SECOND)
                        nxt_unlock = UL_ARMED;
                    else if (wr_data16 == `PPC_KEY_FIRST)
                        nxt_unlock = UL_FIRST;
                    else
                        nxt_unlock = UL_IDLE;
                end
                UL_ARMED: begin
                    if (wr_data16 == `PPC_KEY_FIRST)
                        nxt_unlock = UL_FIRST;
                    else
                        nxt_unlock = UL_IDLE;
                end
                default: begin
                    nxt_unlock = UL_IDLE;
                end
            endcase
        end
    end

    // refused-write flag; a new refusal wins over a clear
    always @* begin
        nxt_refused = refused_ff;
        if (wr_status && wb_sel_i[0] && wb_dat_i[`PPC_ST_REFUSED])
            nxt_refused = 1'b0;
        if (wr_ctl && !ctl_allowed)
            nxt_refused = 1'b1;
    end

    // fault and limit handling selects
    always @* begin
        nxt_handling = handling_ff;
        if (wr_handling && wb_sel_i[0])
            nxt_handling = wb_dat_i[1:0];
    end

    // read data for the cycle that raises ack; unmapped reads give zero
    always @* begin
        nxt_dat = 32'h0000_0000;
        case (wb_adr_i)
            `PPC_ADR_PIN_CTL: begin
                nxt_dat[15:0] = pin_io_ctl_ff;
            end
            `PPC_ADR_UNLOCK: begin
                nxt_dat[1:0] = unlock_ff;
            end
            `PPC_ADR_STATUS: begin
                nxt_dat[`PPC_ST_HIGH_PIN] = high_side_pin_o;
                nxt_dat[`PPC_ST_LOW_PIN]  = low_side_pin_o;
                nxt_dat[`PPC_ST_FAULT]    = fault_on;
                nxt_dat[`PPC_ST_LIMIT]    = limit_on;
                nxt_dat[`PPC_ST_ARMED]    = (unlock_ff == UL_ARMED);
                nxt_dat[`PPC_ST_REFUSED]  = refused_ff;
                nxt_dat[`PPC_ST_LOCK_CFG] = lock_cfg_ff;
                nxt_dat[`PPC_ST_PHASE]    = phase_ff;
            end
            `PPC_ADR_HANDLING: begin
                nxt_dat[1:0] = handling_ff;
            end
            default: begin
                nxt_dat = 32'h0000_0000;
            end
        endcase
    end

    // register state and bus answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_io_ctl_ff <= `PPC_PIN_CTL_RESET;
            handling_ff   <= 2'h0;
            unlock_ff     <= UL_IDLE;
            refused_ff    <= 1'b0;
            lock_cfg_ff   <= 1'b0;
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
        end else begin
            pin_io_ctl_ff <= nxt_pin_io_ctl;
            handling_ff   <= nxt_handling;
            unlock_ff     <= nxt_unlock;
            refused_ff    <= nxt_refused;
            lock_cfg_ff   <= write_lock_config_i;
            wb_ack_o      <= bus_req & ~wb_ack_o;
            wb_dat_o      <= nxt_dat;
        end
    end

    // push-pull phase flips at each period start
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 1'b0;
        end else if (pwm_period_start_i) begin
            phase_ff <= ~phase_ff;
        end
    end

    assign pair_mode = pin_io_ctl_ff[`PPC_MODE_HI:`PPC_MODE_LO];
    assign fault_on  = handling_ff[`PPC_HD_FAULT_SEL] & fault_active_i;
    assign limit_on  = handling_ff[`PPC_HD_LIMIT_SEL] & limit_active_i;

    // generated pair levels per output mode
    always @* begin
        case (pair_mode)
            `PPC_MODE_INDEP: begin
                gen_high = pwm_high_raw_i;
                gen_low  = pwm_low_raw_i;
            end
            `PPC_MODE_PUSHPULL: begin
                gen_high = pwm_high_raw_i & ~phase_ff;
                gen_low  = pwm_high_raw_i & phase_ff;
            end
            `PPC_MODE_REDUND: begin
                gen_high = pwm_high_raw_i;
                gen_low  = pwm_high_raw_i;
            end
            default: begin
                gen_high = pwm_high_raw_i;
                gen_low  = ~pwm_high_raw_i;
            end
        endcase
    end

    // high pin selection
    ppc_pin_drive u_high (
        .owner_i     (pin_io_ctl_ff[`PPC_HIGH_OWNER]),
        .invert_i    (pin_io_ctl_ff[`PPC_HIGH_INVERT]),
        .gen_i       (gen_high),
        .force_en_i  (pin_io_ctl_ff[`PPC_HIGH_FORCE_EN]),
        .force_lvl_i (pin_io_ctl_ff[`PPC_FORCE_HI]),
        .fault_on_i  (fault_on),
        .fault_lvl_i (pin_io_ctl_ff[`PPC_FAULT_HI]),
        .limit_on_i  (limit_on),
        .limit_lvl_i (pin_io_ctl_ff[`PPC_LIMIT_HI]),
        .gpio_i      (gpio_high_i),
        .gpio_oe_i   (gpio_high_oe_i),
        .lvl_o       (high_lvl),
        .oe_o        (high_oe)
    );

    // low pin selection
    ppc_pin_drive u_low (
        .owner_i     (pin_io_ctl_ff[`PPC_LOW_OWNER]),
        .invert_i    (pin_io_ctl_ff[`PPC_LOW_INVERT]),
        .gen_i       (gen_low),
        .force_en_i  (pin_io_ctl_ff[`PPC_LOW_FORCE_EN]),
        .force_lvl_i (pin_io_ctl_ff[`PPC_FORCE_LO]),
        .fault_on_i  (fault_on),
        .fault_lvl_i (pin_io_ctl_ff[`PPC_FAULT_LO]),
        .limit_on_i  (limit_on),
        .limit_lvl_i (pin_io_ctl_ff[`PPC_LIMIT_LO]),
        .gpio_i      (gpio_low_i),
        .gpio_oe_i   (gpio_low_oe_i),
        .lvl_o       (low_lvl),
        .oe_o        (low_oe)
    );

    // pins leave through flip-flops; reset clears level and enable, leaving them undriven
    always @(posedge clk_i) begin
        if (rst_i) begin
            high_side_pin_o    <= 1'b0;
            high_side_pin_oe_o <= 1'b0;
            low_side_pin_o     <= 1'b0;
            low_side_pin_oe_o  <= 1'b0;
        end else begin
            high_side_pin_o    <= high_lvl;
            high_side_pin_oe_o <= high_oe;
            low_side_pin_o     <= low_lvl;
            low_side_pin_oe_o  <= low_oe;
        end
    end

endmodule // ppc_top

`default_nettype wire

// file: dv/ppc_top_asserts.sv
// bus timing and pin selection checker for ppc_top
`timescale 1ns/1ps
`default_nettype none
module ppc_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pwm_high_raw_i,
    input wire logic        pwm_low_raw_i,
    input wire logic        pwm_module_on_i,
    input wire logic        write_lock_config_i,
    input wire logic        fault_active_i,
    input wire logic        limit_active_i,
    input wire logic        gpio_high_i,
    input wire logic        gpio_high_oe_i,
    input wire logic        high_side_pin_o,
    input wire logic        high_side_pin_oe_o,
    input wire logic        low_side_pin_o
);
    logic [15:0] ctl_ff, pc_ff;
    logic [3:0]  in_ff;
    logic [1:0]  hd_ff;
    logic        ok_ff, fc, lc, on, rst_q;
    // shadow registers, trusted only while never locked
    always @(posedge clk_i) begin
        pc_ff <= ctl_ff;
        rst_q <= rst_i;   // covers the attempt on the edge that releases reset
        in_ff <= {pwm_high_raw_i, pwm_low_raw_i, gpio_high_i, gpio_high_oe_i};
        if (rst_i) begin
            ctl_ff <= 16'hc000;
            hd_ff  <= 2'h0;
            ok_ff  <= 1'b1;
        end else begin
            if (write_lock_config_i)
                ok_ff <= 1'b0;
            if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00)
                ctl_ff <= {wb_dat_i[15:12], pwm_module_on_i ? ctl_ff[11:10] :
                           wb_dat_i[11:10], wb_dat_i[9:2], 2'h0};
            if (wb_ack_o && wb_we_i && wb_adr_i == 8'h0c)
                hd_ff <= wb_dat_i[1:0];
        end
    end
    // forcing conditions seen by the pins
    assign fc = hd_ff[0] && fault_active_i;
    assign lc = hd_ff[1] && limit_active_i;
    assign on = ok_ff && ctl_ff[15] && ctl_ff[14];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || rst_q);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_pulse_a: assert property (req_s |=> pulse_s) else $error("ack not one cycle after request");
    no_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper data not 0");
    gpio_pass_a: assert property (ok_ff && !ctl_ff[15] && !fc && !lc |=>
        {high_side_pin_o, high_side_pin_oe_o} == in_ff[1:0]) else $error("gpio not passed");
    own_oe_a: assert property (on |=> high_side_pin_oe_o) else $error("owned pin not driven");
    fault_lvl_a: assert property (on && fc |=>
        {high_side_pin_o, low_side_pin_o} == pc_ff[5:4]) else $error("fault levels wrong");
    limit_lvl_a: assert property (on && !fc && lc |=>
        {high_side_pin_o, low_side_pin_o} == pc_ff[3:2]) else $error("limit levels wrong");
    force_hi_a: assert property (on && !fc && !lc && ctl_ff[9] |=>
        high_side_pin_o == pc_ff[7]) else $error("force level wrong");
    indep_pair_a: assert property (on && !fc && !lc && ctl_ff[11:8] == 4'hc |=>
        {high_side_pin_o, low_side_pin_o} == (in_ff[3:2] ^ pc_ff[13:12])) else $error("indep wrong");
    compl_pair_a: assert property (on && !fc && !lc && ctl_ff[11:8] == 4'h0 |=>
        low_side_pin_o == (!in_ff[3] ^ pc_ff[12])) else $error("complement wrong");
endmodule // ppc_top_asserts
bind ppc_top ppc_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwm_high_raw_i, .pwm_low_raw_i, .pwm_module_on_i,
    .write_lock_config_i, .fault_active_i, .limit_active_i, .gpio_high_i, .gpio_high_oe_i,
    .high_side_pin_o, .high_side_pin_oe_o, .low_side_pin_o);
`default_nettype wire

// file: dv/ppc_stage_model.sv
// power stage gate inputs fed by the pwm pin pair
`timescale 1ns/1ps
`default_nettype none
module ppc_stage_model (
    input  wire logic hs_i,
    input  wire logic hs_oe_i,
    input  wire logic ls_i,
    input  wire logic ls_oe_i,
    output wire logic hs_o,
    output wire logic ls_o
);
    // an undriven gate input sits at its pull-down
    assign hs_o = hs_oe_i ? hs_i : 1'b0;
    assign ls_o = ls_oe_i ? ls_i : 1'b0;
endmodule // ppc_stage_model
`default_nettype wire

// file: dv/ppc_top_tb.sv
// self-checking bench for the pwm pin control block
`timescale 1ns/1ps
`default_nettype none
module ppc_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, high_side_pin_o, high_side_pin_oe_o, low_side_pin_o, low_side_pin_oe_o;
    logic        pwm_high_raw_i = 1'b0, pwm_low_raw_i = 1'b0, pwm_period_start_i = 1'b0;
    logic        pwm_module_on_i = 1'b0, write_lock_config_i = 1'b0;
    logic        fault_active_i = 1'b0, limit_active_i = 1'b0, gpio_high_i = 1'b0;
    logic        gpio_high_oe_i = 1'b0, gpio_low_i = 1'b0, gpio_low_oe_i = 1'b0, hs, ls;
    logic [31:0] exp_q[$];
    int          errors = 0, compares = 0;

    ppc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .pwm_high_raw_i, .pwm_low_raw_i, .pwm_period_start_i,
        .pwm_module_on_i, .write_lock_config_i, .fault_active_i, .limit_active_i, .gpio_high_i,
        .gpio_high_oe_i, .gpio_low_i, .gpio_low_oe_i, .high_side_pin_o, .high_side_pin_oe_o,
        .low_side_pin_o, .low_side_pin_oe_o);
    ppc_stage_model stage (.hs_i(high_side_pin_o), .hs_oe_i(high_side_pin_oe_o),
        .ls_i(low_side_pin_o), .ls_oe_i(low_side_pin_oe_o), .hs_o(hs), .ls_o(ls));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    task automatic print_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    // one classic cycle, released at the edge that sees ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            print_verdict;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // pin pair after its one flop, masked where the level is open
    task automatic pin_chk(input logic [1:0] e, input logic [1:0] k);
        repeat (2) @(posedge clk_i);
        cmp("pins", {30'h0, e & k}, {30'h0, {hs, ls} & k});
    endtask

    // read data checked against the oldest note
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && !wb_we_i)
            cmp("rdata", exp_q.pop_front(), wb_dat_o);

    initial begin
        logic [3:0] r, m;
        logic [1:0] e;
        void'($urandom(32'h05a882b8));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'hc000);
        rd(8'h0c, 32'h0);
        wr(8'h10, 16'hffff);
        rd(8'h10, 32'h0);
        wr(8'h00, 16'h0000);
        repeat (6) begin
            r = 4'($urandom);
            {gpio_high_i, gpio_high_oe_i, gpio_low_i, gpio_low_oe_i} <= r;
            pin_chk({r[3] & r[2], r[1] & r[0]}, 2'h3);
        end
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            wr(8'h00, {2'h3, m, 10'h0});
            repeat (3) begin
                r = 4'($urandom);
                pwm_high_raw_i <= r[3];
                pwm_low_raw_i <= r[2];
                e[1] = r[3] ^ m[3];
                e[0] = m[2] ^ (m[1:0] == 2'h0 ? !r[3] : m[1:0] == 2'h1 ? r[3] : r[2] & m[0]);
                pin_chk(e, 2'h3);
            end
        end
        // push-pull: each period start hands the high raw level to the other pin
        wr(8'h00, 16'hc800);
        pwm_high_raw_i <= 1'b1;
        pwm_period_start_i <= 1'b1;
        @(posedge clk_i);
        pwm_period_start_i <= 1'b0;
        pin_chk(2'h1, 2'h3);
        pwm_period_start_i <= 1'b1;
        @(posedge clk_i);
        pwm_period_start_i <= 1'b0;
        pin_chk(2'h2, 2'h3);
        wr(8'h00, 16'hcf6c);
        wr(8'h0c, 16'h3);
        for (int i = 0; i < 4; i++) begin
            fault_active_i <= i[1];
            limit_active_i <= i[0];
            pin_chk(i[1] ? 2'h2 : i[0] ? 2'h3 : 2'h1, 2'h3);
        end
        wr(8'h0c, 16'h0);
        pin_chk(2'h1, 2'h3);
        fault_active_i <= 1'b0;
        limit_active_i <= 1'b0;
        pwm_module_on_i <= 1'b1;
        wr(8'h00, 16'hc000);
        rd(8'h00, 32'hcc00);
        pwm_module_on_i <= 1'b0;
        pwm_high_raw_i <= 1'b0;
        gpio_high_i <= 1'b0;
        write_lock_config_i <= 1'b1;
        wr(8'h00, 16'h4000);
        rd(8'h00, 32'hcc00);
        wr(8'h04, 16'h5a5a);
        wr(8'h04, 16'ha5a5);
        rd(8'h04, 32'h2);
        wr(8'h00, 16'h4000);
        rd(8'h00, 32'h4000);
        wr(8'h00, 16'hc000);
        rd(8'h00, 32'h4000);
        rd(8'h08, 32'h62);
        wr(8'h08, 16'h0020);
        rd(8'h08, 32'h42);
        print_verdict;
    end
endmodule // ppc_top_tb
`default_nettype wire
